//--- design/sap_dev.sv
// Serial audio input port: receivers, converter paths, processor mux and serial output
//
// Design decisions made here: the cfg_we/cfg_in configuration port, loaded whole in a single write.
`timescale 1ns/1ps
module sap_dev (
  sap_link_if.dev link,
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cfg_we,
  input sap_pkg::sap_cfg_t cfg_in,
  input wire logic [23:0] tx_left,
  input wire logic [23:0] tx_right,
  output sap_pkg::sap_cfg_t cfg_q,
  output logic [5:0][23:0] proc_left,
  output logic [5:0][23:0] proc_right,
  output logic proc_valid
);

  typedef struct packed {
    sap_pkg::sap_cfg_t cfg;
    logic [2:0] bit_p;
    logic [7:0] lr_p;
    logic [7:0][31:0] sh;
    logic [7:0][23:0] tl;
    logic [7:0][23:0] hl;
    logic [7:0][23:0] hr;
    logic [5:0][23:0] pl;
    logic [5:0][23:0] pr;
    logic pv;
    logic [7:0] mcnt;
    logic mbit;
    logic mfrm;
    logic [4:0] mpos;
    logic [2:0] oe;
    logic tx_lr_p;
    logic [4:0] tx_pos;
    logic [23:0] tx_word;
    logic txd;
  } sap_dev_st_t;

  sap_dev_st_t s;
  sap_dev_st_t n;
  logic [2:0] rise;
  logic [2:0] fall;
  logic [7:0][1:0] rpair;
  logic [7:0][1:0] rline;
  logic [3:0] masked;
  logic [7:0] rx_rise;
  logic [7:0] rx_lvl;
  logic tx_fall;
  logic tx_lvl;
  logic [1:0] drv_pair;

  assign rise = link.bit_clock & ~s.bit_p;
  assign fall = ~link.bit_clock & s.bit_p;
  // Receivers 0-3 sync lines, 4 stereo converter, 5-7 six-channel converter
  assign rpair = {{3{s.cfg.six_ch_rate_converter_pair}}, s.cfg.stereo_rate_converter_pair, {4{s.cfg.sync_pair}}};
  assign rline = {s.cfg.six_ch_rate_converter_line, s.cfg.stereo_rate_converter_line, 2'h3, 2'h2, 2'h1, 2'h0};

  always_comb begin
    for (int j = 0; j < 4; j++) begin
      masked[j] = (s.cfg.stereo_rate_converter_en && (s.cfg.stereo_rate_converter_line == 2'(j))) ||
                  (s.cfg.six_ch_rate_converter_en && ((s.cfg.six_ch_rate_converter_line[0] == 2'(j)) ||
                                     (s.cfg.six_ch_rate_converter_line[1] == 2'(j)) ||
                                     (s.cfg.six_ch_rate_converter_line[2] == 2'(j))));
    end
  end

  // Per-receiver pair selection; code 3 folds onto pair 0 everywhere
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      rx_rise[i] = sap_pkg::sap_sel(rise, rpair[i]);
      rx_lvl[i] = sap_pkg::sap_sel(link.frame_clock, rpair[i]);
    end
    tx_fall = sap_pkg::sap_sel(fall, s.cfg.sync_pair);
    tx_lvl = sap_pkg::sap_sel(link.frame_clock, s.cfg.sync_pair);
    drv_pair = (s.cfg.sync_pair == 2'h3) ? 2'h0 : s.cfg.sync_pair;
  end

  always_comb begin
    logic lr;
    logic strobe;
    logic [23:0] w;
    lr = 1'b0;
    strobe = 1'b0;
    w = 24'h000000;
    n = s;
    n.pv = 1'b0;
    n.bit_p = link.bit_clock;
    if (cfg_we) begin
      n.cfg = cfg_in;
    end

    // Master clock generator, frame toggles after 32 bit periods
    if (s.mcnt == 8'h00) begin
      n.mcnt = sap_pkg::SAP_MST_HALF_CYC - 8'h01;
      n.mbit = ~s.mbit;
      if (s.mbit) begin
        n.mpos = s.mpos + 5'h01;
        if (s.mpos == sap_pkg::SAP_LAST_BIT) begin
          n.mfrm = ~s.mfrm;
        end
      end
    end else begin
      n.mcnt = s.mcnt - 8'h01;
    end
    // Only the sync pair is driven; the far end keeps the others
    if (s.cfg.master) begin
      n.oe = 3'h1 << drv_pair;
    end else begin
      n.oe = 3'h0;
    end

    // Receivers sample on the rising bit clock edge
    for (int i = 0; i < 8; i++) begin
      if (rx_rise[i]) begin
        lr = rx_lvl[i];
        if (lr != s.lr_p[i]) begin
          w = sap_pkg::sap_extract(s.cfg.fmt, s.cfg.wl, s.sh[i]);
          if (sap_pkg::sap_is_left(s.cfg.fmt, s.lr_p[i])) begin
            n.tl[i] = w;
          end else begin
            // Commit both halves together so a pair never straddles frames
            n.hl[i] = s.tl[i];
            n.hr[i] = w;
            if (i == 0) begin
              strobe = 1'b1;
            end
          end
        end
        n.lr_p[i] = lr;
        n.sh[i] = {s.sh[i][30:0], link.serial_in[rline[i]]};
      end
    end

    // Processor frame: sync lines direct, converters sampled and held
    if (strobe) begin
      n.pv = 1'b1;
      for (int j = 0; j < 4; j++) begin
        if (masked[j]) begin
          n.pl[j] = 24'h000000;
          n.pr[j] = 24'h000000;
        end else begin
          n.pl[j] = n.hl[j];
          n.pr[j] = n.hr[j];
        end
      end
      if (s.cfg.conv_b_sel) begin
        n.pl[2] = s.cfg.six_ch_rate_converter_en ? n.hl[6] : 24'h000000;
        n.pr[2] = s.cfg.six_ch_rate_converter_en ? n.hr[6] : 24'h000000;
      end
      if (s.cfg.conv_c_sel) begin
        n.pl[3] = s.cfg.six_ch_rate_converter_en ? n.hl[7] : 24'h000000;
        n.pr[3] = s.cfg.six_ch_rate_converter_en ? n.hr[7] : 24'h000000;
      end
      // A disabled converter reads zero rather than stale held samples
      n.pl[4] = 24'h000000;
      n.pr[4] = 24'h000000;
      n.pl[5] = 24'h000000;
      n.pr[5] = 24'h000000;
      if (s.cfg.six_ch_rate_converter_en) begin
        n.pl[4] = n.hl[5];
        n.pr[4] = n.hr[5];
      end
      if (s.cfg.stereo_rate_converter_en) begin
        n.pl[5] = n.hl[4];
        n.pr[5] = n.hr[4];
      end
    end

    // Serial output changes on the falling edge of the sync pair
    if (tx_fall) begin
      lr = tx_lvl;
      if (lr != s.tx_lr_p) begin
        // Word sampled at slot start, so a mid-slot change waits a slot
        n.tx_pos = 5'h00;
        if (sap_pkg::sap_is_left(s.cfg.fmt, lr)) begin
          n.tx_word = tx_left;
        end else begin
          n.tx_word = tx_right;
        end
      end else begin
        n.tx_pos = s.tx_pos + 5'h01;
      end
      n.tx_lr_p = lr;
      n.txd = sap_pkg::sap_tx_bit(s.cfg.fmt, s.cfg.wl, n.tx_pos, n.tx_word);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
      s.cfg <= sap_pkg::SAP_CFG_RST;
    end else begin
      s <= n;
    end
  end

  // Pin outputs come straight from state flops
  assign link.dev_bit_o = {3{s.mbit}};
  assign link.dev_frm_o = {3{s.mfrm}};
  assign link.dev_bit_oe = s.oe;
  assign link.dev_frm_oe = s.oe;
  assign link.serial_out_0 = s.txd;
  assign cfg_q = s.cfg;
  assign proc_left = s.pl;
  assign proc_right = s.pr;
  assign proc_valid = s.pv;

endmodule

//--- include/sap_pkg.sv
// Shared constants, types and helpers for the serial audio input port and its far end
package sap_pkg;

  typedef enum logic [1:0] {
    SAP_FMT_I2S = 2'h0,
    SAP_FMT_LEFT_JUSTIFIED = 2'h1,
    SAP_FMT_RIGHT_JUSTIFIED = 2'h2
  } sap_fmt_t;

  typedef enum logic [1:0] {
    SAP_WL_16 = 2'h0,
    SAP_WL_20 = 2'h1,
    SAP_WL_24 = 2'h2
  } sap_wl_t;

  typedef struct packed {
    logic master;
    logic [1:0] sync_pair;
    sap_fmt_t fmt;
    sap_wl_t wl;
    logic stereo_rate_converter_en;
    logic [1:0] stereo_rate_converter_pair;
    logic [1:0] stereo_rate_converter_line;
    logic six_ch_rate_converter_en;
    logic [1:0] six_ch_rate_converter_pair;
    logic [2:0][1:0] six_ch_rate_converter_line;
    logic conv_b_sel;
    logic conv_c_sel;
  } sap_cfg_t;

  localparam sap_cfg_t SAP_CFG_RST = '{
    master: 1'b0,
    sync_pair: 2'h1,
    fmt: SAP_FMT_I2S,
    wl: SAP_WL_24,
    stereo_rate_converter_en: 1'b0,
    stereo_rate_converter_pair: 2'h0,
    stereo_rate_converter_line: 2'h0,
    six_ch_rate_converter_en: 1'b0,
    six_ch_rate_converter_pair: 2'h2,
    six_ch_rate_converter_line: 6'h39,
    conv_b_sel: 1'b0,
    conv_c_sel: 1'b0
  };

  localparam int SAP_CORE_HZ = 25000000;
  localparam int SAP_MASTER_FS_HZ = 48000;
  localparam int SAP_BITS_PER_FRAME = 64;
  // Longest half period that still reaches the target rate
  localparam logic [7:0] SAP_MST_HALF_CYC =
    8'(SAP_CORE_HZ / (SAP_MASTER_FS_HZ * SAP_BITS_PER_FRAME * 2));
  localparam logic [4:0] SAP_LAST_BIT = 5'h1f;

  // Far-end register map, byte addresses
  localparam logic [7:0] SAP_HR_CTRL = 8'h00;
  localparam logic [7:0] SAP_HR_DIV0 = 8'h04;
  localparam logic [7:0] SAP_HR_DIV1 = 8'h08;
  localparam logic [7:0] SAP_HR_DIV2 = 8'h0c;
  localparam logic [7:0] SAP_HR_TXL = 8'h10;
  localparam logic [7:0] SAP_HR_TXR = 8'h14;
  localparam logic [7:0] SAP_HR_RXL = 8'h18;
  localparam logic [7:0] SAP_HR_RXR = 8'h1c;
  localparam logic [7:0] SAP_HR_STAT = 8'h20;
  localparam int SAP_HC_DRV_LSB = 0;
  localparam int SAP_HC_FMT_LSB = 3;
  localparam int SAP_HC_WL_LSB = 5;
  localparam int SAP_HC_RXP_LSB = 7;
  localparam int SAP_HC_LNP_LSB = 9;
  localparam logic [16:0] SAP_HC_RST = 17'h0aac7;
  localparam logic [7:0] SAP_DIV_RST = SAP_MST_HALF_CYC;

  function automatic logic sap_sel(logic [2:0] v, logic [1:0] s);
    case (s)
      2'h1: sap_sel = v[1];
      2'h2: sap_sel = v[2];
      default: sap_sel = v[0];
    endcase
  endfunction

  // Slot whose frame level is lvl carries left data
  function automatic logic sap_is_left(sap_fmt_t f, logic lvl);
    sap_is_left = (f == SAP_FMT_I2S) ? ~lvl : lvl;
  endfunction

  function automatic logic [5:0] sap_len(sap_wl_t w);
    case (w)
      SAP_WL_16: sap_len = 6'h10;
      SAP_WL_20: sap_len = 6'h14;
      default: sap_len = 6'h18;
    endcase
  endfunction

  // sh[31] is the first bit of the finished slot; result is left aligned
  function automatic logic [23:0] sap_extract(sap_fmt_t f, sap_wl_t w, logic [31:0] sh);
    logic [23:0] raw;
    logic [23:0] m;
    m = (w == SAP_WL_16) ? 24'hffff00 : (w == SAP_WL_20) ? 24'hfffff0 : 24'hffffff;
    case (f)
      SAP_FMT_I2S: raw = sh[30:7];
      SAP_FMT_LEFT_JUSTIFIED: raw = sh[31:8];
      default: begin
        case (w)
          SAP_WL_16: raw = {sh[15:0], 8'h00};
          SAP_WL_20: raw = {sh[19:0], 4'h0};
          default: raw = sh[23:0];
        endcase
      end
    endcase
    sap_extract = raw & m;
  endfunction

  function automatic logic sap_tx_bit(sap_fmt_t f, sap_wl_t w, logic [4:0] pos,
                                      logic [23:0] word);
    logic [5:0] len;
    logic [5:0] off;
    logic [5:0] rel;
    len = sap_len(w);
    case (f)
      SAP_FMT_I2S: off = 6'h01;
      SAP_FMT_LEFT_JUSTIFIED: off = 6'h00;
      default: off = 6'h20 - len;
    endcase
    rel = {1'b0, pos} - off;
    if (({1'b0, pos} >= off) && (rel < len)) begin
      sap_tx_bit = word[5'h17 - rel[4:0]];
    end else begin
      sap_tx_bit = 1'b0;
    end
  endfunction

endpackage

//--- include/sap_link_if.sv
// Pin-level link between the audio port and its far end
`timescale 1ns/1ps
interface sap_link_if;
  logic [2:0] bit_clock;
  logic [2:0] frame_clock;
  logic [2:0] dev_bit_o;
  logic [2:0] dev_bit_oe;
  logic [2:0] dev_frm_o;
  logic [2:0] dev_frm_oe;
  logic [2:0] host_bit_o;
  logic [2:0] host_bit_oe;
  logic [2:0] host_frm_o;
  logic [2:0] host_frm_oe;
  logic [3:0] serial_in;
  logic serial_out_0;

  // Undriven pins read low
  assign bit_clock = (dev_bit_oe & dev_bit_o) | (host_bit_oe & host_bit_o);
  assign frame_clock = (dev_frm_oe & dev_frm_o) | (host_frm_oe & host_frm_o);

  modport dev (
    input bit_clock,
    input frame_clock,
    input serial_in,
    output dev_bit_o,
    output dev_bit_oe,
    output dev_frm_o,
    output dev_frm_oe,
    output serial_out_0
  );

  modport host (
    input bit_clock,
    input frame_clock,
    input serial_out_0,
    output host_bit_o,
    output host_bit_oe,
    output host_frm_o,
    output host_frm_oe,
    output serial_in
  );
endinterface

//--- design/sap_host.sv
// Far-end audio source/sink: clock generators, four transmitters, one receiver, Wishbone slave
`timescale 1ns/1ps
module sap_host (
  sap_link_if.host link,
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  typedef struct packed {
    logic [16:0] ctrl;
    logic [2:0][7:0] div;
    logic [23:0] txl;
    logic [23:0] txr;
    logic [23:0] rxl;
    logic [23:0] rxr;
    logic [23:0] rtl;
    logic [15:0] frames;
    logic [2:0][7:0] cnt;
    logic [2:0] bitc;
    logic [2:0] frm;
    logic [2:0][4:0] pos;
    logic [2:0] bit_p;
    logic [31:0] rsh;
    logic rlr_p;
    logic [3:0][4:0] tpos;
    logic [3:0] tlr_p;
    logic [3:0][23:0] tword;
    logic [3:0] sd;
    logic ack;
    logic [31:0] dat;
  } sap_host_st_t;

  sap_host_st_t s;
  sap_host_st_t n;
  sap_pkg::sap_fmt_t fmt;
  sap_pkg::sap_wl_t wl;
  logic [1:0] rxp;
  logic [2:0] rise;
  logic [2:0] fall;
  logic [31:0] wmask;

  assign fmt = sap_pkg::sap_fmt_t'(s.ctrl[sap_pkg::SAP_HC_FMT_LSB +: 2]);
  assign wl = sap_pkg::sap_wl_t'(s.ctrl[sap_pkg::SAP_HC_WL_LSB +: 2]);
  assign rxp = s.ctrl[sap_pkg::SAP_HC_RXP_LSB +: 2];
  assign rise = link.bit_clock & ~s.bit_p;
  assign fall = ~link.bit_clock & s.bit_p;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_comb begin
    logic lr;
    logic [1:0] lp;
    logic [31:0] old;
    logic [31:0] wv;
    lr = 1'b0;
    lp = 2'h0;
    old = 32'h00000000;
    wv = 32'h00000000;
    n = s;
    n.bit_p = link.bit_clock;

    // Independent rate per pair, so converter inputs can be asynchronous
    for (int p = 0; p < 3; p++) begin
      if (s.cnt[p] == 8'h00) begin
        n.cnt[p] = (s.div[p] == 8'h00) ? 8'h00 : s.div[p] - 8'h01;
        n.bitc[p] = ~s.bitc[p];
        if (s.bitc[p]) begin
          n.pos[p] = s.pos[p] + 5'h01;
          if (s.pos[p] == sap_pkg::SAP_LAST_BIT) begin
            n.frm[p] = ~s.frm[p];
          end
        end
      end else begin
        n.cnt[p] = s.cnt[p] - 8'h01;
      end
    end

    // Line transmitters, each on its own pair, change on falling edge
    for (int k = 0; k < 4; k++) begin
      lp = s.ctrl[sap_pkg::SAP_HC_LNP_LSB + 2 * k +: 2];
      if (sap_pkg::sap_sel(fall, lp)) begin
        lr = sap_pkg::sap_sel(link.frame_clock, lp);
        if (lr != s.tlr_p[k]) begin
          n.tpos[k] = 5'h00;
          n.tword[k] = sap_pkg::sap_is_left(fmt, lr) ? s.txl : s.txr;
        end else begin
          n.tpos[k] = s.tpos[k] + 5'h01;
        end
        n.tlr_p[k] = lr;
        n.sd[k] = sap_pkg::sap_tx_bit(fmt, wl, n.tpos[k], n.tword[k]);
      end
    end

    // Receiver of the device's serial output
    if (sap_pkg::sap_sel(rise, rxp)) begin
      lr = sap_pkg::sap_sel(link.frame_clock, rxp);
      if (lr != s.rlr_p) begin
        if (sap_pkg::sap_is_left(fmt, s.rlr_p)) begin
          n.rtl = sap_pkg::sap_extract(fmt, wl, s.rsh);
        end else begin
          n.rxl = s.rtl;
          n.rxr = sap_pkg::sap_extract(fmt, wl, s.rsh);
          n.frames = s.frames + 16'h0001;
        end
      end
      n.rlr_p = lr;
      n.rsh = {s.rsh[30:0], link.serial_out_0};
    end

    // Classic Wishbone: ack one cycle after request, dropped the next
    n.ack = wb_cyc_i && wb_stb_i && !s.ack;
    if (wb_cyc_i && wb_stb_i && !s.ack) begin
      case (wb_adr_i)
        sap_pkg::SAP_HR_CTRL: old = {15'h0000, s.ctrl};
        sap_pkg::SAP_HR_DIV0: old = {24'h000000, s.div[0]};
        sap_pkg::SAP_HR_DIV1: old = {24'h000000, s.div[1]};
        sap_pkg::SAP_HR_DIV2: old = {24'h000000, s.div[2]};
        sap_pkg::SAP_HR_TXL: old = {8'h00, s.txl};
        sap_pkg::SAP_HR_TXR: old = {8'h00, s.txr};
        sap_pkg::SAP_HR_RXL: old = {8'h00, s.rxl};
        sap_pkg::SAP_HR_RXR: old = {8'h00, s.rxr};
        sap_pkg::SAP_HR_STAT: old = {16'h0000, s.frames};
        default: old = 32'h00000000;
      endcase
      n.dat = old;
    end
    if (wb_cyc_i && wb_stb_i && wb_we_i && s.ack) begin
      case (wb_adr_i)
        sap_pkg::SAP_HR_CTRL: old = {15'h0000, s.ctrl};
        sap_pkg::SAP_HR_DIV0: old = {24'h000000, s.div[0]};
        sap_pkg::SAP_HR_DIV1: old = {24'h000000, s.div[1]};
        sap_pkg::SAP_HR_DIV2: old = {24'h000000, s.div[2]};
        sap_pkg::SAP_HR_TXL: old = {8'h00, s.txl};
        default: old = {8'h00, s.txr};
      endcase
      wv = (old & ~wmask) | (wb_dat_i & wmask);
      case (wb_adr_i)
        sap_pkg::SAP_HR_CTRL: n.ctrl = wv[16:0];
        sap_pkg::SAP_HR_DIV0: n.div[0] = wv[7:0];
        sap_pkg::SAP_HR_DIV1: n.div[1] = wv[7:0];
        sap_pkg::SAP_HR_DIV2: n.div[2] = wv[7:0];
        sap_pkg::SAP_HR_TXL: n.txl = wv[23:0];
        sap_pkg::SAP_HR_TXR: n.txr = wv[23:0];
        default: n.dat = s.dat;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
      s.ctrl <= sap_pkg::SAP_HC_RST;
      s.div <= {3{sap_pkg::SAP_DIV_RST}};
    end else begin
      s <= n;
    end
  end

  // Slave default of the device relies on these clocks being driven
  assign link.host_bit_oe = s.ctrl[sap_pkg::SAP_HC_DRV_LSB +: 3];
  assign link.host_frm_oe = s.ctrl[sap_pkg::SAP_HC_DRV_LSB +: 3];
  assign link.host_bit_o = s.bitc;
  assign link.host_frm_o = s.frm;
  assign link.serial_in = s.sd;
  assign wb_dat_o = s.dat;
  assign wb_ack_o = s.ack;

endmodule

//--- tb/sap_monitor.sv
// Concurrent checks on the pin-level link of the audio port
`timescale 1ns/1ps
module sap_monitor (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [2:0] bit_clock,
  input wire logic [2:0] frame_clock,
  input wire logic [2:0] dev_bit_o,
  input wire logic [2:0] dev_bit_oe,
  input wire logic [2:0] dev_frm_o,
  input wire logic [2:0] dev_frm_oe,
  input wire logic [3:0] serial_in,
  input wire logic serial_out_0
);
  default clocking mon_cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  logic [5:0] rises_r;
  logic armed_r;
  logic frm_r;
  logic clk_r;
  logic frm_edge;
  logic clk_rise;

  assign frm_edge = frame_clock[0] != frm_r;
  assign clk_rise = bit_clock[0] & ~clk_r;

  // Pair 0 bit clock rises since its last frame edge; first slot is partial
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rises_r <= 6'h00;
      armed_r <= 1'b0;
      frm_r <= 1'b0;
      clk_r <= 1'b0;
    end else begin
      rises_r <= frm_edge ? {5'h00, clk_rise} : rises_r + {5'h00, clk_rise};
      armed_r <= armed_r | frm_edge;
      frm_r <= frame_clock[0];
      clk_r <= bit_clock[0];
    end
  end

  sequence s_gen_high;
    dev_bit_o[0] [*4] ##1 !dev_bit_o[0];
  endsequence

  sequence s_fall0;
    !bit_clock[0] && clk_r;
  endsequence

  AST_RST_QUIET: assert property (disable iff (1'b0) rst |=>
      dev_bit_oe == 3'h0 && dev_frm_oe == 3'h0 && !serial_out_0)
    else $error("link outputs active after reset");
  AST_OE_PAIRED: assert property (dev_bit_oe == dev_frm_oe)
    else $error("bit and frame clock enables differ");
  AST_OE_SINGLE: assert property ($onehot0(dev_bit_oe))
    else $error("device drives more than one clock pair");
  AST_GEN_COMMON: assert property ((dev_bit_o == 3'h0 || dev_bit_o == 3'h7) &&
      (dev_frm_o == 3'h0 || dev_frm_o == 3'h7))
    else $error("generator outputs differ between pairs");
  AST_GEN_HALF: assert property ($rose(dev_bit_o[0]) |-> s_gen_high)
    else $error("master bit clock high phase is not four cycles");
  AST_HOST_HALF: assert property ($rose(bit_clock[0]) |=> bit_clock[0])
    else $error("bit clock high for a single cycle");
  AST_SLOT_32: assert property (armed_r && frm_edge |-> rises_r == 6'h20)
    else $error("slot does not hold 32 bit clocks");
  AST_FRM_AT_FALL: assert property (frm_edge |-> s_fall0)
    else $error("frame clock moved away from a bit clock fall");
  AST_DIN_LOW: assert property ($changed(serial_in) |-> !bit_clock[1])
    else $error("serial input changed while bit clock high");
  AST_DOUT_LOW: assert property ($changed(serial_out_0) |-> !bit_clock[1])
    else $error("serial output changed while bit clock high");
endmodule

//--- tb/serial_audio_input_port_tb.sv
// Self-checking bench joining the audio port and its far end
`timescale 1ns/1ps
module serial_audio_input_port_tb;
  typedef struct {logic [31:0] exp; int src;} sap_note_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cfg_we = 1'b0;
  sap_pkg::sap_cfg_t cfg_in = sap_pkg::SAP_CFG_RST;
  sap_pkg::sap_cfg_t cfg_q;
  sap_pkg::sap_cfg_t c;
  logic [23:0] tx_left = 24'h000000;
  logic [23:0] tx_right = 24'h000000;
  logic [5:0][23:0] proc_left;
  logic [5:0][23:0] proc_right;
  logic proc_valid;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'hf;
  logic [31:0] wb_dat = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic arm = 1'b0;
  logic [31:0] seed = 32'h00000024;
  logic [23:0] hl;
  logic [23:0] hr;
  sap_note_t notes[$];
  int n_mismatch = 0;
  int num_checks = 0;
  int f;
  int w;

  sap_link_if link();
  sap_dev u_sap_dev (.link(link), .core_clk(core_clk), .rst(rst), .cfg_we(cfg_we),
    .cfg_in(cfg_in), .tx_left(tx_left), .tx_right(tx_right), .cfg_q(cfg_q),
    .proc_left(proc_left), .proc_right(proc_right), .proc_valid(proc_valid));
  sap_host u_sap_host (.link(link), .core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  sap_monitor u_mon (.core_clk(core_clk), .rst(rst), .bit_clock(link.bit_clock),
    .frame_clock(link.frame_clock), .dev_bit_o(link.dev_bit_o), .dev_bit_oe(link.dev_bit_oe),
    .dev_frm_o(link.dev_frm_o), .dev_frm_oe(link.dev_frm_oe), .serial_in(link.serial_in),
    .serial_out_0(link.serial_out_0));

  initial begin
    forever #20 core_clk = ~core_clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Bits past the word length are expected as zero
  function automatic logic [23:0] msk(logic [23:0] v, sap_pkg::sap_wl_t wl);
    case (wl)
      sap_pkg::SAP_WL_16: return v & 24'hffff00;
      sap_pkg::SAP_WL_20: return v & 24'hfffff0;
      default: return v;
    endcase
  endfunction

  task automatic summarize();
    if (notes.size() > 0) begin
      n_mismatch++;
      $display("[FAIL] notes expected 0 seen %0d", notes.size());
    end
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(string nm, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic give_up(string nm);
    n_mismatch++;
    $display("[FAIL] %s expected event seen timeout", nm);
    summarize();
  endtask

  // Classic cycle: hold until ack is seen, release at the edge that samples it
  task automatic wb(logic we, logic [7:0] a, logic [31:0] d);
    int i;
    @(posedge core_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    if (wb_ack_o !== 1'b1) give_up("wb_ack_o");
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e);
    notes.push_back('{e, -1});
    wb(1'b0, a, 32'h00000000);
  endtask

  task automatic set_cfg(sap_pkg::sap_cfg_t v);
    @(posedge core_clk);
    cfg_in <= v;
    cfg_we <= 1'b1;
    @(posedge core_clk);
    cfg_we <= 1'b0;
    @(negedge core_clk);
    check("cfg_q", 32'(v), 32'(cfg_q));
  endtask

  task automatic frames(int n);
    int i;
    for (i = 0; i < 3000 && n > 0; i++) begin
      @(negedge core_clk);
      if (proc_valid === 1'b1) n--;
    end
    if (n > 0) give_up("proc_valid");
  endtask

  // New words both ways, settle, then one frame and the far receiver are checked
  task automatic run(logic [5:0] live, sap_pkg::sap_wl_t wl);
    int s;
    logic [31:0] e;
    hl = 24'(rnd());
    hr = 24'(rnd());
    wb(1'b1, sap_pkg::SAP_HR_TXL, {8'h00, hl});
    wb(1'b1, sap_pkg::SAP_HR_TXR, {8'h00, hr});
    @(posedge core_clk);
    tx_left <= 24'(rnd());
    tx_right <= 24'(rnd());
    frames(3);
    // Let the pulse just counted pass so the check lands on the next frame
    @(negedge core_clk);
    for (s = 0; s < 12; s++) begin
      e = live[s % 6] ? {8'h00, msk(s < 6 ? hl : hr, wl)} : 32'h00000000;
      notes.push_back('{e, s < 6 ? s : s + 4});
    end
    arm = 1'b1;
    frames(1);
    rd(sap_pkg::SAP_HR_RXL, {8'h00, msk(tx_left, wl)});
    rd(sap_pkg::SAP_HR_RXR, {8'h00, msk(tx_right, wl)});
  endtask

  // Outputs are taken at the rising edge, before the design updates them
  always @(posedge core_clk) begin
    sap_note_t n;
    logic [23:0] got;
    if (wb_ack_o === 1'b1 && !wb_we && notes.size() > 0) begin
      n = notes.pop_front();
      check("wb_dat_o", n.exp, wb_dat_o);
    end
    if (proc_valid === 1'b1 && arm) begin
      arm = 1'b0;
      while (notes.size() > 0 && notes[0].src >= 0) begin
        n = notes.pop_front();
        got = (n.src < 10) ? proc_left[n.src] : proc_right[n.src - 10];
        check($sformatf("proc slot %0d", n.src), n.exp, {8'h00, got});
      end
    end
  end

  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    check("cfg_q", 32'(sap_pkg::SAP_CFG_RST), 32'(cfg_q));
    rd(sap_pkg::SAP_HR_CTRL, 32'h0000aac7);
    rd(sap_pkg::SAP_HR_DIV0, 32'h00000004);
    wb(1'b1, 8'h40, 32'hffffffff);
    rd(8'h40, 32'h00000000);
    for (f = 0; f < 3; f++) begin
      for (w = 0; w < 3; w++) begin
        c = sap_pkg::SAP_CFG_RST;
        c.fmt = sap_pkg::sap_fmt_t'(f);
        c.wl = sap_pkg::sap_wl_t'(w);
        wb(1'b1, sap_pkg::SAP_HR_CTRL, {15'h0, 8'h55, 2'h1, 2'(w), 2'(f), 3'h7});
        set_cfg(c);
        run(6'h0f, c.wl);
      end
    end
    wb(1'b1, sap_pkg::SAP_HR_CTRL, 32'h0000aac7);
    c = sap_pkg::SAP_CFG_RST;
    c.stereo_rate_converter_en = 1'b1;
    c.stereo_rate_converter_pair = 2'h1;
    c.stereo_rate_converter_line = 2'h2;
    set_cfg(c);
    run(6'h2b, c.wl);
    c.stereo_rate_converter_en = 1'b0;
    c.six_ch_rate_converter_en = 1'b1;
    c.six_ch_rate_converter_pair = 2'h1;
    c.six_ch_rate_converter_line = 6'h38;
    c.conv_b_sel = 1'b1;
    c.conv_c_sel = 1'b1;
    set_cfg(c);
    run(6'h1e, c.wl);
    c.conv_b_sel = 1'b0;
    set_cfg(c);
    run(6'h1a, c.wl);
    // Sync port, far lines and far receiver all moved to pair 0
    wb(1'b1, sap_pkg::SAP_HR_CTRL, 32'h00000047);
    c = sap_pkg::SAP_CFG_RST;
    c.sync_pair = 2'h0;
    set_cfg(c);
    run(6'h0f, c.wl);
    // Far end lets go of pair 1 before the port starts driving it
    wb(1'b1, sap_pkg::SAP_HR_CTRL, 32'h0000aac5);
    c = sap_pkg::SAP_CFG_RST;
    c.master = 1'b1;
    set_cfg(c);
    run(6'h0f, c.wl);
    @(negedge core_clk);
    check("dev_bit_oe", 32'h2, {29'h0, link.dev_bit_oe});
    check("dev_frm_oe", 32'h2, {29'h0, link.dev_frm_oe});
    summarize();
  end
endmodule
